// >>> core/drs_pulse_filter.sv
`include "drs_cfg.svh"
// qualifies the reset input: high for minimum width, then released
module drs_pulse_filter #(
   parameter logic [31:0] MIN_CYC = 32'(`DRS_PULSE_MIN_CYC)
) (
   input wire logic clk,       // system clock
   input wire logic rst_n,     // sync reset, active low
   input wire logic level_in,  // raw input level
   output logic held,          // input held at least minimum width
   output logic done           // one-cycle pulse on qualified release
);
   typedef struct packed {
      logic [31:0] cnt;
      logic held;
      logic done;
   } drs_pf_t;
   drs_pf_t q;
   drs_pf_t next_q;

   // count high time; short pulses are dropped on release
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      if (level_in) begin
         if (q.cnt < MIN_CYC) begin
            next_q.cnt = q.cnt + 32'h0000_0001;
         end
         if (q.cnt >= MIN_CYC - 32'h0000_0001) begin
            next_q.held = 1'b1;
         end
      end else begin
         next_q.done = q.held;
         next_q.held = 1'b0;
         next_q.cnt = 32'h0000_0000;
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign held = q.held;
   assign done = q.done;
endmodule // drs_pulse_filter

// >>> core/drs_reset_seq.sv
// Notes on behaviour
// - reset from trip returns to normal
// - reset acts on full on-then-off pulse
// - alarm output drops within 30 ms
// - function code 18: motor off, clear trip
// - segment pattern while input held
// - stop key resets only under alarm
// - reset input normally-open only
// - power-up performs same reset
// - remote operator: key only after power-up
// - reset while running: motor coasts
// - no off-delay: outputs off together
// - off-delay outputs linger about 1 s
// - restart at once if run active
// - guard error if run at power-up
// - guard cleared by reset resumes run
// - guard blocks, else resumes, power-up run
`include "drs_cfg.svh"
module drs_reset_seq #(
   parameter logic [31:0] PULSE_MIN_CYC = 32'(`DRS_PULSE_MIN_CYC),
   parameter logic [31:0] OFF_EXTRA_CYC = 32'(`DRS_OFF_EXTRA_CYC),
   parameter logic [31:0] KEY_WIN_CYC = 32'(`DRS_KEY_WIN_CYC),
   parameter logic [31:0] SEG_CYC = 32'(`DRS_SEG_CYC)
) (
   input wire logic clk,                    // system clock
   input wire logic rst_n,                  // power-on, sync, active low
   input wire logic terminal_in,            // raw input terminal level
   input wire logic [7:0] func_code,        // function assigned to input
   input wire logic nc_polarity,            // normally-closed requested
   input wire logic run_cmd,                // run command level
   input wire logic trip_event,             // pulse: fault detected
   input wire logic unattended_start_guard, // guard function enabled
   input wire logic stop_key,               // pulse: keypad stop/reset
   input wire logic remote_op,              // hand-held operator present
   input wire logic [2:0] out_req,          // logic outputs wanted on
   input wire logic [2:0] out_has_delay,    // output has nonzero off-delay
   output logic motor_on,                   // motor output enabled
   output logic alarm,                      // alarm output
   output logic guard_error,                // guard error shown
   output logic seg_alt,                    // keypad alternating segments
   output logic polarity_err,               // nc setting refused
   output logic [2:0] out_on                // logic outputs
);
   localparam int NO = `DRS_NUM_OUT;

   // true when the input carries the reset function
   function automatic logic is_reset_func(input logic [7:0] code);
      return code == `DRS_RESET_FUNC_CODE;
   endfunction

   typedef struct packed {
      drs_pkg::drs_state_t st;
      logic [31:0] key_cnt;
      logic key_open;
      logic [31:0] seg_cnt;
      logic seg_phase;
      logic motor_on;
      logic alarm;
      logic guard_error;
      logic seg_alt;
      logic polarity_err;
      logic [2:0] out_on;
   } drs_seq_t;
   drs_seq_t q;
   drs_seq_t next_q;

   logic rs_sel;
   logic rs_level;
   logic rs_held;
   logic rs_done;
   logic [NO-1:0] lag_on;

   assign rs_sel = is_reset_func(func_code) && !nc_polarity;
   assign rs_level = rs_sel && terminal_in;

   drs_pulse_filter #(
      .MIN_CYC(PULSE_MIN_CYC)
   ) u_filter (
      .clk(clk),
      .rst_n(rst_n),
      .level_in(rs_level),
      .held(rs_held),
      .done(rs_done)
   );

   // off-delay timers; an output with delay lingers after reset
   genvar g;
   generate
      for (g = 0; g < NO; g = g + 1) begin : g_lag
         logic [31:0] c;
         logic on;
         always_ff @(posedge clk) begin
            if (!rst_n) begin
               c <= 32'h0000_0000;
               on <= 1'b0;
            end else if (rs_held && out_has_delay[g]) begin
               if (c < OFF_EXTRA_CYC) begin
                  c <= c + 32'h0000_0001;
                  on <= out_req[g]; // keep what is wanted, not the cut copy
               end else begin
                  on <= 1'b0;
               end
            end else begin
               c <= 32'h0000_0000;
               on <= 1'b0;
            end
         end
         assign lag_on[g] = on;
      end
   endgenerate

   // main sequencer
   always_comb begin
      next_q = q;
      next_q.polarity_err = is_reset_func(func_code) && nc_polarity;
      if (q.key_cnt < KEY_WIN_CYC) begin
         next_q.key_cnt = q.key_cnt + 32'h0000_0001;
      end else begin
         next_q.key_open = 1'b0;
      end
      if (rs_held) begin
         if (q.seg_cnt >= SEG_CYC - 32'h0000_0001) begin
            next_q.seg_cnt = 32'h0000_0000;
            next_q.seg_phase = !q.seg_phase;
         end else begin
            next_q.seg_cnt = q.seg_cnt + 32'h0000_0001;
         end
         next_q.seg_alt = 1'b1;
      end else begin
         next_q.seg_cnt = 32'h0000_0000;
         next_q.seg_phase = 1'b0;
         next_q.seg_alt = 1'b0;
      end
      case (q.st)
         drs_pkg::DRS_POWERUP: begin
            next_q.alarm = 1'b0;
            if (unattended_start_guard && run_cmd) begin
               next_q.guard_error = 1'b1;
               next_q.alarm = 1'b1;
               next_q.st = drs_pkg::DRS_GUARD;
            end else begin
               next_q.motor_on = run_cmd;
               next_q.st = drs_pkg::DRS_NORMAL;
            end
         end
         drs_pkg::DRS_NORMAL: begin
            next_q.motor_on = run_cmd;
            if (trip_event) begin
               next_q.motor_on = 1'b0;
               next_q.alarm = 1'b1;
               next_q.st = drs_pkg::DRS_TRIP;
            end
         end
         drs_pkg::DRS_TRIP, drs_pkg::DRS_GUARD: begin
            next_q.motor_on = 1'b0;
            // stop key only under alarm; remote window
            if (stop_key && (!remote_op || q.key_open)) begin
               next_q.alarm = 1'b0;
               next_q.guard_error = 1'b0;
               next_q.st = drs_pkg::DRS_NORMAL;
            end
         end
         drs_pkg::DRS_RESET: begin
            next_q.motor_on = 1'b0;
            // act on release; back to normal
            if (rs_done) begin
               next_q.st = drs_pkg::DRS_NORMAL;
            end
         end
         default: begin
            next_q.st = drs_pkg::DRS_POWERUP;
         end
      endcase
      if (rs_held) begin
         next_q.st = drs_pkg::DRS_RESET;
         next_q.motor_on = 1'b0;
         next_q.alarm = 1'b0;
         next_q.guard_error = 1'b0;
      end else if (rs_done) begin
         // restart at once if run active
         next_q.motor_on = run_cmd;
      end
      // outputs off while reset input held unless delayed
      next_q.out_on = rs_held ? 3'b000 : out_req;
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q <= '0;
         q.st <= drs_pkg::DRS_POWERUP;
         q.key_open <= 1'b1;
      end else begin
         q <= next_q;
      end
   end

   assign motor_on = q.motor_on;
   assign alarm = q.alarm;
   assign guard_error = q.guard_error;
   assign seg_alt = q.seg_alt && q.seg_phase;
   assign polarity_err = q.polarity_err;
   assign out_on = q.out_on | lag_on;
endmodule // drs_reset_seq

// >>> include/drs_cfg.svh
`ifndef DRS_CFG_SVH
`define DRS_CFG_SVH
// timebase and timing figures
`define DRS_CLK_HZ 200000000
`define DRS_PULSE_MIN_MS 12
`define DRS_PULSE_MIN_CYC ((`DRS_CLK_HZ / 1000) * `DRS_PULSE_MIN_MS)
`define DRS_ALARM_CLR_MS 30
`define DRS_ALARM_CLR_CYC ((`DRS_CLK_HZ / 1000) * `DRS_ALARM_CLR_MS)
`define DRS_OFF_EXTRA_MS 1000
`define DRS_OFF_EXTRA_CYC ((`DRS_CLK_HZ / 1000) * `DRS_OFF_EXTRA_MS)
`define DRS_KEY_WIN_MS 3000
`define DRS_KEY_WIN_CYC ((`DRS_CLK_HZ / 1000) * `DRS_KEY_WIN_MS)
`define DRS_SEG_MS 250
`define DRS_SEG_CYC ((`DRS_CLK_HZ / 1000) * `DRS_SEG_MS)
`define DRS_RESET_FUNC_CODE 8'h12
`define DRS_NUM_OUT 3
`define DRS_CNT_W 32
`endif

// >>> include/drs_pkg.sv
package drs_pkg;
   // main sequencer states, one-hot
   typedef enum logic [4:0] {
      DRS_POWERUP = 5'b0_0001,
      DRS_NORMAL  = 5'b0_0010,
      DRS_TRIP    = 5'b0_0100,
      DRS_GUARD   = 5'b0_1000,
      DRS_RESET   = 5'b1_0000
   } drs_state_t;
endpackage

// >>> test/drs_chk.sv
module drs_chk #(
   parameter logic [31:0] PULSE_MIN_CYC = 32'h0000_0008, // min hold
   parameter logic [31:0] OFF_EXTRA_CYC = 32'h0000_0014, // linger
   parameter logic [31:0] KEY_WIN_CYC = 32'h0000_0032,   // key window
   parameter logic [31:0] SEG_CYC = 32'h0000_0004        // segment step
) (
   input wire logic clk,                    // clock
   input wire logic rst_n,                  // reset
   input wire logic terminal_in,            // terminal
   input wire logic [7:0] func_code,        // function
   input wire logic nc_polarity,            // nc asked
   input wire logic run_cmd,                // run
   input wire logic trip_event,             // fault
   input wire logic unattended_start_guard, // guard
   input wire logic stop_key,               // key
   input wire logic remote_op,              // remote
   input wire logic [2:0] out_req,          // wanted
   input wire logic [2:0] out_has_delay,    // delayed
   input wire logic motor_on,               // motor
   input wire logic alarm,                  // alarm
   input wire logic guard_error,            // guard error
   input wire logic seg_alt,                // segments
   input wire logic polarity_err,           // nc refused
   input wire logic [2:0] out_on            // outputs
);
   timeunit 1ns;
   timeprecision 1ps;
   // terminal armed for reset
   wire en = func_code == 8'h12 && !nc_polarity;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_held; (terminal_in && en) [*8]; endsequence
   sequence s_long; s_held ##1 terminal_in [*8]; endsequence
   alarm_clear_a:
   assert property (s_held |-> ##[0:2] !alarm)
      else $error("alarm kept in reset");
   motor_coast_a:
   assert property (s_held |-> ##[0:2] !motor_on)
      else $error("motor driven in reset");
   out_drop_a:
   assert property (s_held |-> ##[0:2] !(out_on & ~out_has_delay))
      else $error("output kept in reset");
   seg_idle_a:
   assert property (!terminal_in [*4] |-> !seg_alt)
      else $error("segments without reset");
   seg_turn_a:
   assert property (s_long |-> seg_alt != $past(seg_alt, 4))
      else $error("segments not alternating");
   hold_only_a:
   assert property (alarm && !terminal_in && !stop_key && !$past(stop_key)
      |=> alarm) else $error("alarm dropped without cause");
   nc_flag_a:
   assert property (func_code == 8'h12 && nc_polarity |=> polarity_err)
      else $error("nc setting accepted");
   guard_set_a:
   assert property ($rose(rst_n) && unattended_start_guard && run_cmd
      |-> ##[1:3] guard_error && !motor_on) else $error("no guard error");
   key_idle_a:
   assert property (stop_key && !alarm && motor_on && run_cmd && !terminal_in
      && !trip_event |=> motor_on) else $error("key acted without alarm");
endmodule // drs_chk

bind drs_reset_seq drs_chk #(
   .PULSE_MIN_CYC(PULSE_MIN_CYC),
   .OFF_EXTRA_CYC(OFF_EXTRA_CYC),
   .KEY_WIN_CYC(KEY_WIN_CYC),
   .SEG_CYC(SEG_CYC)
) i_drs_chk (.*);

// >>> test/drs_contact.sv
module drs_contact (
   input wire logic clk,         // clock
   input wire logic start,       // begin a closure
   input wire logic [7:0] width, // cycles closed
   output logic level            // terminal level
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] left = 8'h00;
   always_ff @(posedge clk) begin
      if (start)
         left <= width;
      else if (left != 8'h00)
         left <= left - 8'h01;
   end
   // contact closed while count runs
   assign level = left != 8'h00;
endmodule // drs_contact

// >>> test/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, term, nc = 1'b0, run = 1'b1;
   logic trip = 1'b0, guard = 1'b0, key = 1'b0, rop = 1'b0;
   logic [7:0] wid = 8'h00, func = 8'h12;
   logic [2:0] out_on;
   logic [2:0] oreq = 3'h7;
   logic motor_on, alarm, guard_error, seg_alt, polarity_err;
   int err_count = 0, n_tests = 0;
   // clock
   always #2.5 clk = ~clk;
   drs_contact i_drs_contact (.clk(clk), .start(go), .width(wid), .level(term));
   drs_reset_seq #(.PULSE_MIN_CYC(32'h0000_0008), .OFF_EXTRA_CYC(32'h0000_0014),
      .KEY_WIN_CYC(32'h0000_0032), .SEG_CYC(32'h0000_0004)) i_drs_reset_seq (
      .clk(clk), .rst_n(rst_n), .terminal_in(term), .func_code(func),
      .nc_polarity(nc), .run_cmd(run), .trip_event(trip),
      .unattended_start_guard(guard), .stop_key(key), .remote_op(rop),
      .out_req(oreq), .out_has_delay(3'h4), .motor_on(motor_on), .alarm(alarm),
      .guard_error(guard_error), .seg_alt(seg_alt),
      .polarity_err(polarity_err), .out_on(out_on));
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic got, input logic exp, input string what);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: %s", $time, what);
      end
   endtask
   task automatic pulse(input logic [7:0] w);
      @(posedge clk) go <= 1'b1;
      wid <= w;
      @(posedge clk) go <= 1'b0;
      cyc(int'(w) + 5);
   endtask
   task automatic tripit;
      @(posedge clk) trip <= 1'b1;
      @(posedge clk) trip <= 1'b0;
      cyc(3);
   endtask
   task automatic keyit;
      @(posedge clk) key <= 1'b1;
      @(posedge clk) key <= 1'b0;
      cyc(3);
   endtask
   task automatic t_trip;
      cyc(3);
      chk(motor_on, 1'b1, "no run at power-up");
      tripit();
      chk(alarm, 1'b1, "trip gave no alarm");
      pulse(8'h05);
      chk(alarm, 1'b1, "short pulse acted");
      pulse(8'h09);
      chk(alarm, 1'b0, "alarm left");
      chk(motor_on, 1'b1, "no restart");
      $display("trip test done");
   endtask
   task automatic t_outs;
      @(posedge clk) go <= 1'b1;
      wid <= 8'h28;
      @(posedge clk) go <= 1'b0;
      cyc(12);
      chk(motor_on, 1'b0, "motor not coasting");
      chk(out_on === 3'h4, 1'b1, "outputs at hold");
      cyc(26);
      chk(out_on === 3'h0, 1'b1, "output still lingers");
      cyc(10);
      chk(seg_alt, 1'b0, "display not back");
      @(posedge clk) oreq <= 3'h1;
      cyc(2);
      chk(out_on === 3'h1, 1'b1, "outputs not following");
      @(posedge clk) oreq <= 3'h7;
      cyc(2);
      $display("output test done");
   endtask
   task automatic t_key;
      keyit();
      chk(motor_on, 1'b1, "key stopped run");
      tripit();
      keyit();
      chk(alarm, 1'b0, "key kept alarm");
      rop <= 1'b1;
      tripit();
      keyit();
      chk(alarm, 1'b1, "late remote key acted");
      rop <= 1'b0;
      pulse(8'h09);
      $display("key test done");
   endtask
   task automatic t_nc;
      nc <= 1'b1;
      tripit();
      chk(polarity_err, 1'b1, "nc accepted");
      pulse(8'h09);
      chk(alarm, 1'b1, "nc input acted");
      nc <= 1'b0;
      func <= 8'h07;
      pulse(8'h09);
      chk(alarm, 1'b1, "other function acted");
      func <= 8'h12;
      // run command off before the alarm reset
      @(posedge clk) run <= 1'b0;
      pulse(8'h09);
      chk(alarm, 1'b0, "reset refused");
      chk(motor_on, 1'b0, "restart with run off");
      @(posedge clk) run <= 1'b1;
      cyc(2);
      $display("polarity test done");
   endtask
   task automatic t_guard;
      @(posedge clk) rst_n <= 1'b0;
      guard <= 1'b1;
      cyc(3);
      @(posedge clk) rst_n <= 1'b1;
      cyc(4);
      chk(guard_error, 1'b1, "no guard error");
      chk(motor_on, 1'b0, "guard let run");
      pulse(8'h09);
      chk(guard_error, 1'b0, "guard error kept");
      chk(motor_on, 1'b1, "no resume");
      rop <= 1'b1;
      tripit();
      keyit();
      chk(alarm, 1'b0, "early remote key refused");
      $display("guard test done");
   endtask
   task automatic final_report;
      $display("tests %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // main sequence
   initial begin
      cyc(20);
      @(posedge clk) rst_n <= 1'b1;
      t_trip();
      t_outs();
      t_key();
      t_nc();
      t_guard();
      final_report();
   end
   // watchdog
   initial begin
      #25000;
      err_count++;
      final_report();
   end
endmodule // testbench
